// file: fpec_device.sv
// Flash array with program/erase control register and interlocks
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`include "fpec_defs.svh"
`timescale 1ns/1ns
// What this block does
// - Read-only flag shows program voltage present
// - Wipe select writable only while hv_apply clear
// - Wipe 1 erases all; boot only unguarded
// - First array write under capture fills latches
// - Capture enable needs program voltage to set, not to stay set
// - hv_apply sets only after latches written
// - Under hv_apply, writes change hv_apply only
// - Clearing capture under hv_apply is ignored
// - hv_apply with capture cleared does nothing
// - Array read result follows control state
// - Control register usable while hv_apply set
// - Misaligned word takes one extra cycle
// - Normal array writes are discarded
// - Erased reads 1; program only clears
// - Program one byte or aligned word
// - After capture, array writes ignored
// - Reset vector at top of array
// - Software orders wipe, capture, write, apply
// - Software owns all pulse timing
// - Software applies margin pulses after verify
// - No new operation or read mid-cycle
// - Guarded boot block refuses programming
// - Low-power request ends operation at once when wait bit set
module fpec_device
  import fpec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic program_voltage_pin,
  input wire logic low_power_req,
  output logic hv_active,
  fpec_if.device bus
);
  typedef struct packed {
    logic [2:0] vsync;
    logic volt_ok;
    logic supply_level_flag;
    logic wipe_select;
    logic hold_capture_enable;
    logic hv_apply;
    logic boot_guard;
    logic wait_clock_halt;
    logic latched;
    logic [14:0] lat_addr;
    logic [15:0] lat_data;
    logic lat_size8;
    logic second;
    logic ack;
    logic ignored;
    logic [15:0] rdata;
  } fpec_dev_state_type;

  fpec_dev_state_type st_reg;
  fpec_dev_state_type st_next;
  logic [15:0] mem [0:`FPEC_ARRAY_WORDS-1];
  logic [13:0] widx;
  logic [13:0] widx_next;
  logic [15:0] rd_lo;
  logic [15:0] rd_hi;
  logic [7:0] ctl_rd;
  logic misaligned;
  logic in_boot;
  logic prog_fire;
  logic erase_fire;
  logic [15:0] prog_mask;

  assign widx = bus.addr[14:1];
  assign widx_next = widx + 14'h0001;
  assign rd_lo = mem[widx];
  assign rd_hi = mem[widx_next];
  assign misaligned = bus.addr[0] && !bus.byte_size_signal;
  assign in_boot = st_reg.lat_addr >= `FPEC_BOOT_BASE;
  assign ctl_rd = {st_reg.wait_clock_halt, 2'b00, st_reg.boot_guard, st_reg.wipe_select,
    st_reg.hold_capture_enable, st_reg.hv_apply, st_reg.supply_level_flag};
  assign hv_active = st_reg.hv_apply;
  assign bus.ack = st_reg.ack;
  assign bus.ignored = st_reg.ignored;
  assign bus.rdata = st_reg.rdata;
  // Pulse rising edge does the array work; pulse length is the software's job
  assign prog_fire = st_next.hv_apply && !st_reg.hv_apply && !st_reg.wipe_select;
  assign erase_fire = st_next.hv_apply && !st_reg.hv_apply && st_reg.wipe_select;

  always_comb begin
    // Byte lane by size and address bit zero
    if (st_reg.lat_size8) begin
      prog_mask = st_reg.lat_addr[0] ? 16'h00FF : 16'hFF00;
    end else begin
      prog_mask = 16'hFFFF;
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.vsync = {st_reg.vsync[1:0], program_voltage_pin};
    if (st_reg.vsync[2] == st_reg.vsync[1]) begin
      st_next.volt_ok = st_reg.vsync[1];
    end
    st_next.supply_level_flag = st_reg.volt_ok;
    st_next.ack = 1'b0;
    st_next.ignored = 1'b0;
    if (bus.req && !st_reg.ack) begin
      case (bus.op)
        FPEC_OP_CTL_RD: begin
          st_next.ack = 1'b1;
          st_next.rdata = {8'h00, ctl_rd};
        end
        FPEC_OP_CTL_WR: begin
          st_next.ack = 1'b1;
          if (st_reg.hv_apply) begin
            st_next.hv_apply = bus.wdata[`FPEC_BIT_HV];
          end else begin
            st_next.wipe_select = bus.wdata[`FPEC_BIT_WIPE];
            st_next.boot_guard = bus.wdata[`FPEC_BIT_BOOT];
            st_next.wait_clock_halt = bus.wdata[`FPEC_BIT_WAIT];
            st_next.hold_capture_enable = bus.wdata[`FPEC_BIT_LATCH] &&
              (st_reg.hold_capture_enable || st_reg.volt_ok);
            if (!bus.wdata[`FPEC_BIT_LATCH]) begin
              st_next.latched = 1'b0;
            end
            // Needs capture already on, latches filled and capture kept
            st_next.hv_apply = bus.wdata[`FPEC_BIT_HV] && st_reg.hold_capture_enable &&
              st_reg.latched && bus.wdata[`FPEC_BIT_LATCH];
          end
        end
        FPEC_OP_WRITE: begin
          st_next.ack = 1'b1;
          if (st_reg.hold_capture_enable && !st_reg.latched && !st_reg.hv_apply) begin
            st_next.latched = 1'b1;
            st_next.lat_addr = bus.addr;
            st_next.lat_data = bus.wdata;
            st_next.lat_size8 = bus.byte_size_signal;
          end else begin
            st_next.ignored = 1'b1;
          end
        end
        FPEC_OP_READ: begin
          if (st_reg.hv_apply) begin
            st_next.ack = 1'b1;
            st_next.ignored = 1'b1;
            st_next.rdata = 16'h0000;
          end else if (st_reg.hold_capture_enable && !st_reg.wipe_select && st_reg.latched) begin
            st_next.ack = 1'b1;
            st_next.rdata = st_reg.lat_data;
          end else if (misaligned && !st_reg.second) begin
            st_next.second = 1'b1;
          end else begin
            st_next.ack = 1'b1;
            st_next.second = 1'b0;
            if (misaligned) begin
              st_next.rdata = {rd_lo[7:0], rd_hi[15:8]};
            end else if (bus.byte_size_signal) begin
              st_next.rdata = {8'h00, bus.addr[0] ? rd_lo[7:0] : rd_lo[15:8]};
            end else begin
              st_next.rdata = rd_lo;
            end
          end
        end
        default: st_next.ack = 1'b1;
      endcase
    end
    if (low_power_req && st_reg.wait_clock_halt) begin
      st_next.hv_apply = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.boot_guard <= `FPEC_BOOT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Array: no reset, starts erased; reset vector word readable from top
  initial begin
    for (int i = 0; i < `FPEC_ARRAY_WORDS; i++) begin
      mem[i] = `FPEC_ERASED_WORD;
    end
  end

  // Plain clocked process: the initial preload above is a second writer of the array
  always @(posedge clk_sys) begin
    if (erase_fire) begin
      for (int i = 0; i < `FPEC_ARRAY_WORDS; i++) begin
        if (!st_reg.boot_guard || (15'(i * 2) < `FPEC_BOOT_BASE)) begin
          mem[i] <= `FPEC_ERASED_WORD;
        end
      end
    end else if (prog_fire && !(st_reg.boot_guard && in_boot)) begin
      mem[st_reg.lat_addr[14:1]] <= mem[st_reg.lat_addr[14:1]] &
        (st_reg.lat_data | ~prog_mask);
    end
  end
endmodule : fpec_device

// file: fpec_defs.svh
// Constants for the flash program/erase control block
`ifndef FPEC_DEFS_SVH
`define FPEC_DEFS_SVH
`define FPEC_AW 15
`define FPEC_ARRAY_WORDS 16384
`define FPEC_CTL_OFS 8'h00
`define FPEC_HOST_CMD_OFS 12'h000
`define FPEC_HOST_ADDR_OFS 12'h004
`define FPEC_HOST_DATA_OFS 12'h008
`define FPEC_HOST_STAT_OFS 12'h00C
`define FPEC_HOST_RDATA_OFS 12'h010
`define FPEC_BIT_SUPPLY 0
`define FPEC_BIT_HV 1
`define FPEC_BIT_LATCH 2
`define FPEC_BIT_WIPE 3
`define FPEC_BIT_BOOT 4
`define FPEC_BIT_WAIT 7
`define FPEC_BOOT_BASE 15'h7800
`define FPEC_VECTOR_ADDR 15'h7FFE
`define FPEC_ERASED_WORD 16'hFFFF
`define FPEC_CTL_RESET 8'h00
`define FPEC_BOOT_RESET 1'b1
`endif

// file: fpec_pkg.sv
// Types shared by both ends of the flash program/erase control link
package fpec_pkg;
  typedef enum logic [1:0] {
    FPEC_OP_READ,
    FPEC_OP_WRITE,
    FPEC_OP_CTL_RD,
    FPEC_OP_CTL_WR
  } fpec_op_type;
endpackage : fpec_pkg

// file: fpec_if.sv
// Internal bus between the CPU-side master and the flash controller
`timescale 1ns/1ns
interface fpec_if;
  import fpec_pkg::*;
  logic req;
  fpec_op_type op;
  logic [14:0] addr;
  logic byte_size_signal;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  logic ignored;
  modport device (input req, input op, input addr, input byte_size_signal, input wdata,
    output rdata, output ack, output ignored);
  modport host (output req, output op, output addr, output byte_size_signal,
    output wdata, input rdata, input ack, input ignored);
endinterface : fpec_if

// file: fpec_host.sv
// CPU-side master: APB registers turned into flash bus cycles
`include "fpec_defs.svh"
`timescale 1ns/1ns
module fpec_host
  import fpec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  fpec_if.host bus
);
  typedef struct packed {
    logic busy;
    logic ignored;
    fpec_op_type op;
    logic size8;
    logic [14:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
  } fpec_host_state_type;

  fpec_host_state_type st_reg;
  fpec_host_state_type st_next;
  logic wr_en;
  logic rd_en;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign bus.req = st_reg.busy;
  assign bus.op = st_reg.op;
  assign bus.addr = st_reg.addr;
  assign bus.byte_size_signal = st_reg.size8;
  assign bus.wdata = st_reg.wdata;

  always_comb begin
    st_next = st_reg;
    pslverr = 1'b0;
    prdata = 32'h0000_0000;
    if (st_reg.busy && bus.ack) begin
      st_next.busy = 1'b0;
      st_next.ignored = bus.ignored;
      st_next.rdata = bus.rdata;
    end
    if (psel && penable) begin
      case (paddr)
        `FPEC_HOST_CMD_OFS: begin
          // Command issue is dropped while a cycle is still running
          if (wr_en && !st_reg.busy) begin
            st_next.busy = 1'b1;
            st_next.op = fpec_op_type'(pwdata[1:0]);
            st_next.size8 = pwdata[2];
          end
        end
        `FPEC_HOST_ADDR_OFS: begin
          if (wr_en && !st_reg.busy) begin
            st_next.addr = pwdata[14:0];
          end
          prdata = {17'h0_0000, st_reg.addr};
        end
        `FPEC_HOST_DATA_OFS: begin
          if (wr_en && !st_reg.busy) begin
            st_next.wdata = pwdata[15:0];
          end
          prdata = {16'h0000, st_reg.wdata};
        end
        `FPEC_HOST_STAT_OFS: prdata = {30'h0000_0000, st_reg.ignored, st_reg.busy};
        `FPEC_HOST_RDATA_OFS: prdata = {16'h0000, st_reg.rdata};
        default: pslverr = 1'b1;
      endcase
    end
    if (rd_en == 1'b0) begin
      prdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : fpec_host

// file: fpec_assertions.sv
// Protocol checks on the flash control link
`timescale 1ns/1ns
module fpec_assertions
  import fpec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic req,
  input wire fpec_op_type op,
  input wire logic [14:0] addr,
  input wire logic byte_size_signal,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic ack,
  input wire logic ignored
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  sequence s_plain_start;
    $rose(req) && op != FPEC_OP_READ;
  endsequence
  sequence s_answer;
    ack ##1 !req;
  endsequence
  AST_PLAIN_ONE_CYCLE: assert property (s_plain_start |-> ##1 s_answer)
    else $error("register or write access not answered next cycle");
  AST_ALIGNED_READ: assert property ($rose(req) && op == FPEC_OP_READ &&
    (byte_size_signal || !addr[0]) |=> ack)
    else $error("aligned read not answered next cycle");
  AST_MISALIGNED_READ: assert property ($rose(req) && op == FPEC_OP_READ &&
    !byte_size_signal && addr[0] |-> ##[1:2] ack)
    else $error("misaligned read answer late");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  AST_ACK_NEEDS_REQ: assert property (ack |-> req)
    else $error("ack without request");
  AST_IGNORED_WITH_ACK: assert property (ignored |-> ack)
    else $error("ignored outside ack");
  AST_HOLD_REQUEST: assert property (req && !ack |=>
    req && $stable(op) && $stable(addr) && $stable(wdata))
    else $error("request changed before ack");
  AST_CTL_READ_TAKEN: assert property (ack && op == FPEC_OP_CTL_RD |-> !ignored)
    else $error("control read refused");
  AST_RDATA_HOLDS: assert property (!ack |-> $stable(rdata))
    else $error("read data moved without ack");
endmodule : fpec_assertions

// file: tb_top.sv
// Self-checking bench for the flash control link
`timescale 1ns/1ns
module tb_top
  import fpec_pkg::*;
;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] r;
  logic pready;
  logic pslverr;
  logic err;
  logic hv_active;
  logic program_voltage_pin = 1'b0;
  logic low_power_req = 1'b0;
  logic [15:0] rd;
  logic ign;
  logic sz8 = 1'b0;
  int fail_count = 0;
  int checked = 0;
  fpec_if u_fpec_if();
  fpec_host u_fpec_host(.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(u_fpec_if.host));
  fpec_device u_fpec_device(.clk_sys(clk_sys), .arst_n(arst_n),
    .program_voltage_pin(program_voltage_pin), .low_power_req(low_power_req),
    .hv_active(hv_active), .bus(u_fpec_if.device));
  fpec_assertions u_fpec_assertions(.clk_sys(clk_sys), .arst_n(arst_n), .req(u_fpec_if.req),
    .op(u_fpec_if.op), .addr(u_fpec_if.addr), .byte_size_signal(u_fpec_if.byte_size_signal),
    .wdata(u_fpec_if.wdata), .rdata(u_fpec_if.rdata), .ack(u_fpec_if.ack),
    .ignored(u_fpec_if.ignored));
  always #2 clk_sys = ~clk_sys;
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One link transfer: address, data, command, then poll until idle
  task flash(input fpec_op_type op, input logic [14:0] a, input logic [15:0] d);
    int n;
    apb(1'b1, 12'h004, 32'(a));
    apb(1'b1, 12'h008, 32'(d));
    apb(1'b1, 12'h000, {29'h0000_0000, sz8, op});
    n = 0;
    do begin
      apb(1'b0, 12'h00C, 32'h0000_0000);
      n++;
    end while (r[0] !== 1'b0 && n < 50);
    if (r[0] !== 1'b0) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, r[0], 1'b0);
    end
    ign = r[1];
    apb(1'b0, 12'h010, 32'h0000_0000);
    rd = r[15:0];
  endtask : flash
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task ctl_wr(input logic [7:0] v);
    flash(FPEC_OP_CTL_WR, 15'h0000, {8'h00, v});
  endtask : ctl_wr
  task ctl_chk(input logic [7:0] v);
    flash(FPEC_OP_CTL_RD, 15'h0000, 16'h0000);
    chk({8'h00, rd[7:0]}, {8'h00, v});
  endtask : ctl_chk
  task arr_chk(input logic [14:0] a, input logic [15:0] v);
    flash(FPEC_OP_READ, a, 16'h0000);
    chk(rd, v);
  endtask : arr_chk
  // Capture, latch, pulse and release twice, restore
  task prog(input logic [7:0] c, input logic [14:0] a, input logic [15:0] d);
    ctl_wr(c | 8'h04);
    flash(FPEC_OP_WRITE, a, d);
    ctl_wr(c | 8'h06);
    ctl_wr(c | 8'h04);
    ctl_wr(c | 8'h06);
    ctl_wr(c | 8'h04);
    ctl_wr(c);
  endtask : prog
  task final_report;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    #200000;
    fail_count++;
    final_report;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    ctl_chk(8'h10);
    arr_chk(15'h7FFE, 16'hFFFF);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({15'h0000, err}, 16'h0001);
    ctl_wr(8'h14);
    ctl_chk(8'h10);
    program_voltage_pin <= 1'b1;
    repeat (10) @(posedge clk_sys);
    ctl_chk(8'h11);
    flash(FPEC_OP_WRITE, 15'h0100, 16'h1234);
    chk({15'h0000, ign}, 16'h0001);
    arr_chk(15'h0100, 16'hFFFF);
    ctl_wr(8'h12);
    ctl_chk(8'h11);
    ctl_wr(8'h14);
    ctl_wr(8'h16);
    ctl_chk(8'h15);
    flash(FPEC_OP_WRITE, 15'h0100, 16'h12F0);
    chk({15'h0000, ign}, 16'h0000);
    flash(FPEC_OP_WRITE, 15'h0200, 16'h0000);
    chk({15'h0000, ign}, 16'h0001);
    arr_chk(15'h0100, 16'h12F0);
    ctl_wr(8'h16);
    ctl_chk(8'h17);
    chk({15'h0000, hv_active}, 16'h0001);
    flash(FPEC_OP_READ, 15'h0100, 16'h0000);
    chk({15'h0000, ign}, 16'h0001);
    ctl_wr(8'h08);
    ctl_chk(8'h15);
    ctl_wr(8'h10);
    arr_chk(15'h0100, 16'h12F0);
    prog(8'h10, 15'h0100, 16'hFF0F);
    arr_chk(15'h0100, 16'h1200);
    arr_chk(15'h00FF, 16'hFF12);
    // Erase mode with latches filled: reads stay normal
    ctl_wr(8'h1C);
    flash(FPEC_OP_WRITE, 15'h0100, 16'h0000);
    arr_chk(15'h0100, 16'h1200);
    ctl_wr(8'h10);
    // Byte lanes: odd address is the low byte
    sz8 = 1'b1;
    prog(8'h10, 15'h0501, 16'h0000);
    arr_chk(15'h0500, 16'h00FF);
    arr_chk(15'h0501, 16'h0000);
    sz8 = 1'b0;
    arr_chk(15'h0500, 16'hFF00);
    ctl_wr(8'h14);
    flash(FPEC_OP_WRITE, 15'h0300, 16'h0000);
    ctl_wr(8'h12);
    ctl_chk(8'h11);
    arr_chk(15'h0300, 16'hFFFF);
    prog(8'h10, 15'h7800, 16'h0000);
    arr_chk(15'h7800, 16'hFFFF);
    ctl_wr(8'h94);
    flash(FPEC_OP_WRITE, 15'h0400, 16'h0000);
    ctl_wr(8'h96);
    low_power_req <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({15'h0000, hv_active}, 16'h0000);
    ctl_chk(8'h95);
    low_power_req <= 1'b0;
    // Drop capture so the next sequence fills fresh latches
    ctl_wr(8'h00);
    prog(8'h00, 15'h7800, 16'h0000);
    prog(8'h18, 15'h0000, 16'h0000);
    arr_chk(15'h0100, 16'hFFFF);
    arr_chk(15'h7800, 16'h0000);
    prog(8'h08, 15'h0000, 16'h0000);
    arr_chk(15'h7800, 16'hFFFF);
    final_report;
  end
endmodule : tb_top
